/* File: ccu_map.svh */
// Register offsets, field positions, reset values and counts of the capture/compare unit.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH

// ********
// Register byte offsets on the Wishbone bus
// ********
`define CCU_OFS_CONTROL   6'h00
`define CCU_OFS_SOURCE    6'h04
`define CCU_OFS_VAL_LOW   6'h08
`define CCU_OFS_VAL_HIGH  6'h0c
`define CCU_OFS_FLAG      6'h10
`define CCU_OFS_ENABLE    6'h14

// ********
// Field positions
// ********
`define CCU_CTL_EN_BIT    7
`define CCU_CTL_OUT_BIT   5
`define CCU_SRC_DIR_BIT   7
`define CCU_SRC_OD_BIT    6
`define CCU_FLAG_BIT      0
`define CCU_ENABLE_BIT    0

// ********
// Reset values and counts
// ********
`define CCU_CONTROL_RST   8'h00
`define CCU_SOURCE_RST    8'h80
`define CCU_PS_FOURTH     4'h3
`define CCU_PS_SIXTEENTH  4'hf

`endif

/* File: ccu_pkg.sv */
// Types shared by the capture/compare unit.
// Assumes ccu_map.svh sits in the same folder.
`include "ccu_map.svh"

package ccu_pkg;

    // Mode field encodings of the control register.
    typedef enum logic [3:0]
    {
        CCU_MODE_OFF       = 4'h0,
        CCU_MODE_TOG_CLR   = 4'h1,
        CCU_MODE_TOGGLE    = 4'h2,
        CCU_MODE_CAP_ANY   = 4'h3,
        CCU_MODE_CAP_FALL  = 4'h4,
        CCU_MODE_CAP_RISE  = 4'h5,
        CCU_MODE_CAP_4TH   = 4'h6,
        CCU_MODE_CAP_16TH  = 4'h7,
        CCU_MODE_SET       = 4'h8,
        CCU_MODE_CLEAR     = 4'h9,
        CCU_MODE_PULSE     = 4'ha,
        CCU_MODE_PULSE_CLR = 4'hb,
        CCU_MODE_PWM0      = 4'hc,
        CCU_MODE_PWM1      = 4'hd,
        CCU_MODE_PWM2      = 4'he,
        CCU_MODE_PWM3      = 4'hf
    } ccu_mode_t;

    // Capture source choices.
    typedef enum logic [1:0]
    {
        CCU_SRC_PIN  = 2'h0,
        CCU_SRC_ALT0 = 2'h1,
        CCU_SRC_ALT1 = 2'h2,
        CCU_SRC_ALT2 = 2'h3
    } ccu_src_t;

endpackage

/* File: ccu_top.sv */
// Capture/compare unit with a classic Wishbone register slave.
// Assumes the companion timer count arrives in this clock domain;
// the pad resolves the pin from pin_o and pin_oe_o.
`timescale 1ns/1ps
`include "ccu_map.svh"

module ccu_top
(
    input  wire logic                 clk_i,          // System clock, 100 MHz.
    input  wire logic                 rst_i,          // Synchronous reset, active high.
    input  wire logic                 wb_cyc_i,       // Wishbone cycle.
    input  wire logic                 wb_stb_i,       // Wishbone strobe.
    input  wire logic                 wb_we_i,        // Wishbone write enable.
    input  wire logic [5:0]           wb_adr_i,       // Wishbone byte address.
    input  wire logic [3:0]           wb_sel_i,       // Wishbone byte selects.
    input  wire logic [31:0]          wb_dat_i,       // Wishbone write data.
    output logic      [31:0]          wb_dat_o,       // Wishbone read data.
    output logic                      wb_ack_o,       // Wishbone acknowledge.
    input  wire logic [15:0]          timer_count_i,  // Companion timer count.
    output logic                      timer_clear_o,  // One-cycle timer reset request.
    input  wire logic                 pin_i,          // Level seen on the unit pin.
    output logic                      pin_o,          // Pin output value.
    output logic                      pin_oe_o,       // Pin output enable, high drives.
    input  wire logic [2:0]           alt_src_i,      // Alternative capture sources.
    output logic                      compare_out_o,  // Compare latch for other blocks.
    output logic                      event_flag_o,   // Unit event flag level.
    output logic                      wake_o          // Enabled event, wakes the device.
);
    import ccu_pkg::*;

    // ********
    // Register state
    // ********
    logic             unit_on;         // Unit on bit of the control register.
    ccu_mode_t        unit_mode;       // Mode field of the control register.
    logic [7:0]       source_reg;      // Capture source select and pin configuration.
    logic [15:0]      capture_compare_value; // Captured or compare value.
    logic             unit_event_flag; // Sticky event flag.
    logic             unit_event_enable; // Event enable bit.
    logic             out_latch;       // Compare output latch.
    logic             pulse_active;    // Pulse output is high this cycle.

    // ********
    // Bus decode
    // ********
    logic             bus_req;         // A request is on the bus.
    logic             bus_wr;          // A write takes effect at this edge.
    logic [7:0]       wr_byte;         // Low byte lane of write data.
    logic [7:0]       rd_byte;         // Byte selected for reading.

    assign bus_req = wb_cyc_i & wb_stb_i;
    // Writes act only at the edge where ack is seen, so a held request writes once.
    assign bus_wr  = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // ********
    // Capture input path
    // ********
    logic             src_raw;         // Selected raw capture source.
    logic             sync_a;          // First synchroniser stage.
    logic             sync_b;          // Second synchroniser stage.
    logic             sync_c;          // Previous synchronised level.
    logic             rise;            // Rising edge of the synchronised input.
    logic             fall;            // Falling edge of the synchronised input.
    logic [3:0]       prescale_cnt;    // Capture edge prescaler.
    logic             capture_mode;    // Unit is on and in a capture mode.
    logic             compare_mode;    // Unit is on and in a compare mode.
    logic             capture_evt;     // A capture happens this cycle.

    // Pick the source; the pin input is the pad level, driven or not.
    always_comb
    begin
        unique case (ccu_src_t'(source_reg[1:0]))
            CCU_SRC_PIN:  src_raw = pin_i;
            CCU_SRC_ALT0: src_raw = alt_src_i[0];
            CCU_SRC_ALT1: src_raw = alt_src_i[1];
            CCU_SRC_ALT2: src_raw = alt_src_i[2];
        endcase
    end

    // Two stages so an asynchronous edge makes exactly one event.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end
        else
        begin
            sync_a <= src_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

    assign capture_mode = unit_on & (unit_mode >= CCU_MODE_CAP_ANY)
                        & (unit_mode <= CCU_MODE_CAP_16TH);
    assign compare_mode = unit_on & ((unit_mode == CCU_MODE_TOG_CLR)
                        | (unit_mode == CCU_MODE_TOGGLE)
                        | ((unit_mode >= CCU_MODE_SET) & (unit_mode <= CCU_MODE_PULSE_CLR)));

    // Prescaler counts rising edges in the divided modes; a direct change between
    // divided modes keeps the count, which is why software clears control first.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !capture_mode)
        begin
            prescale_cnt <= 4'h0;
        end
        else if (rise && (unit_mode == CCU_MODE_CAP_4TH || unit_mode == CCU_MODE_CAP_16TH))
        begin
            if (capture_evt)
            begin
                prescale_cnt <= 4'h0;
            end
            else
            begin
                prescale_cnt <= prescale_cnt + 4'h1;
            end
        end
    end

    // Decode the qualifying event for each capture mode.
    always_comb
    begin
        capture_evt = 1'b0;
        if (capture_mode)
        begin
            unique case (unit_mode)
                CCU_MODE_CAP_ANY:  capture_evt = rise | fall;
                CCU_MODE_CAP_FALL: capture_evt = fall;
                CCU_MODE_CAP_RISE: capture_evt = rise;
                CCU_MODE_CAP_4TH:  capture_evt = rise & (prescale_cnt >= `CCU_PS_FOURTH);
                CCU_MODE_CAP_16TH: capture_evt = rise & (prescale_cnt == `CCU_PS_SIXTEENTH);
                default:           capture_evt = 1'b0;
            endcase
        end
    end

    // ********
    // Compare path
    // ********
    logic             equal_now;       // Value equals timer this cycle.
    logic             equal_prev;      // Equality seen last cycle.
    logic             match_evt;       // First cycle of a match.

    // Continuous equality on the shared companion timer.
    assign equal_now = compare_mode & (capture_compare_value == timer_count_i);
    // Only the first cycle of equality acts, so a stalled timer toggles once.
    assign match_evt = equal_now & ~equal_prev;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            equal_prev <= 1'b0;
        end
        else
        begin
            equal_prev <= equal_now;
        end
    end

    // ********
    // Control and source registers
    // ********

    // Control register write; changing mode here may flag a false event.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unit_on   <= 1'(`CCU_CONTROL_RST >> `CCU_CTL_EN_BIT);
            unit_mode <= CCU_MODE_OFF;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_CONTROL)
        begin
            unit_on   <= wr_byte[`CCU_CTL_EN_BIT];
            unit_mode <= ccu_mode_t'(wr_byte[3:0]);
        end
    end

    // Source select, open-drain option and pin direction bit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            source_reg <= `CCU_SOURCE_RST;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_SOURCE)
        begin
            source_reg <= wr_byte;
        end
    end

    // ********
    // Value register
    // ********

    // Capture takes the whole timer count and wins over a byte write in the same
    // cycle; an unread value is simply overwritten.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            capture_compare_value <= 16'h0000;
        end
        else if (capture_evt)
        begin
            capture_compare_value <= timer_count_i;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_VAL_LOW)
        begin
            capture_compare_value[7:0] <= wr_byte;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_VAL_HIGH)
        begin
            capture_compare_value[15:8] <= wr_byte;
        end
    end

    // ********
    // Flag and enable
    // ********

    // Hardware only sets the flag; software clears it by writing zero, and an
    // event in the clearing cycle wins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unit_event_flag <= 1'b0;
        end
        else if (capture_evt || match_evt)
        begin
            unit_event_flag <= 1'b1;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_FLAG)
        begin
            unit_event_flag <= wr_byte[`CCU_FLAG_BIT];
        end
    end

    // Event enable bit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unit_event_enable <= 1'b0;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_ENABLE)
        begin
            unit_event_enable <= wr_byte[`CCU_ENABLE_BIT];
        end
    end

    // Flag and wake outputs; the wake works whether or not the core sleeps.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            event_flag_o <= 1'b0;
            wake_o       <= 1'b0;
        end
        else
        begin
            event_flag_o <= unit_event_flag;
            wake_o       <= unit_event_flag & unit_event_enable;
        end
    end

    // ********
    // Compare output latch and timer clear
    // ********

    // Match action per mode; a zero control write forces the latch low.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_latch    <= 1'b0;
            pulse_active <= 1'b0;
        end
        else if (bus_wr && wb_adr_i == `CCU_OFS_CONTROL && wr_byte == 8'h00)
        begin
            out_latch    <= 1'b0;
            pulse_active <= 1'b0;
        end
        else
        begin
            pulse_active <= 1'b0;
            if (match_evt)
            begin
                unique case (unit_mode)
                    CCU_MODE_TOG_CLR,
                    CCU_MODE_TOGGLE:    out_latch <= ~out_latch;
                    CCU_MODE_SET:       out_latch <= 1'b1;
                    CCU_MODE_CLEAR:     out_latch <= 1'b0;
                    CCU_MODE_PULSE,
                    CCU_MODE_PULSE_CLR: pulse_active <= 1'b1;
                    default:            out_latch <= out_latch;
                endcase
            end
        end
    end

    // Timer reset request only for the two clearing modes.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_clear_o <= 1'b0;
        end
        else
        begin
            timer_clear_o <= match_evt & ((unit_mode == CCU_MODE_TOG_CLR)
                           | (unit_mode == CCU_MODE_PULSE_CLR));
        end
    end

    // ********
    // Pin driver and internal route
    // ********
    logic             drive_level;     // Level the unit wants on the pin.

    assign drive_level = out_latch | pulse_active;

    // Open-drain drives only the low level and leaves high to the pull-up;
    // the direction bit set means input, as out of reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_o         <= 1'b0;
            pin_oe_o      <= 1'b0;
            compare_out_o <= 1'b0;
        end
        else
        begin
            compare_out_o <= drive_level;
            pin_o         <= source_reg[`CCU_SRC_OD_BIT] ? 1'b0 : drive_level;
            pin_oe_o      <= ~source_reg[`CCU_SRC_DIR_BIT]
                           & ~(source_reg[`CCU_SRC_OD_BIT] & drive_level);
        end
    end

    // ********
    // Wishbone answer
    // ********

    // Read mux; unmapped offsets read zero.
    always_comb
    begin
        unique case (wb_adr_i)
            `CCU_OFS_CONTROL:  rd_byte = {unit_on, 1'b0, out_latch, 1'b0, unit_mode};
            `CCU_OFS_SOURCE:   rd_byte = source_reg;
            `CCU_OFS_VAL_LOW:  rd_byte = capture_compare_value[7:0];
            `CCU_OFS_VAL_HIGH: rd_byte = capture_compare_value[15:8];
            `CCU_OFS_FLAG:     rd_byte = {7'h00, unit_event_flag};
            `CCU_OFS_ENABLE:   rd_byte = {7'h00, unit_event_enable};
            default:           rd_byte = 8'h00;
        endcase
    end

    // Ack one cycle after the request and drop it the next, giving every
    // access, mapped or not, a two-cycle answer.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o)
            begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

endmodule

/* File: ccu_timer_model.sv */
// Partner model: the companion 16-bit timer and the unit pin with its pull-up.
// Assumes it shares the system clock and synchronous reset with the unit.
`timescale 1ns/1ps
module ccu_timer_model
(
    input  wire logic        clk_i,      // System clock.
    input  wire logic        rst_i,      // Synchronous reset.
    input  wire logic        run_i,      // Count enable.
    input  wire logic        load_i,     // Load request from the bench.
    input  wire logic [15:0] load_val_i, // Value to load.
    input  wire logic        clear_i,    // Timer reset from the unit.
    output logic      [15:0] count_o,    // Timer count.
    input  wire logic        drv_i,      // Unit pin value.
    input  wire logic        drv_oe_i,   // Unit pin enable.
    input  wire logic        ext_oe_i,   // Outside driver enable.
    input  wire logic        ext_i,      // Outside driver level.
    output logic             pin_o       // Resolved pin level.
);
    // Counts on the system clock only, never asynchronously.
    // A halted timer holds its count, as in sleep with an internal clock.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
            count_o <= 16'h0000;
        else if (load_i)
            count_o <= load_val_i;
        else if (run_i)
            count_o <= count_o + 16'h0001;
    end
    // The unit wins over the outside driver; an undriven pin is pulled up.
    assign pin_o = drv_oe_i ? drv_i : (ext_oe_i ? ext_i : 1'b1);
endmodule

/* File: ccu_top_chk.sv */
// Checker of the capture/compare unit, seeing only its top ports.
// Assumes one clock domain, clk_i, with synchronous reset rst_i.
`timescale 1ns/1ps
`include "ccu_map.svh"
module ccu_top_chk
(
    input wire logic        clk_i,         // System clock.
    input wire logic        rst_i,         // Synchronous reset.
    input wire logic        wb_cyc_i,      // Bus cycle.
    input wire logic        wb_stb_i,      // Bus strobe.
    input wire logic        wb_we_i,       // Bus write.
    input wire logic [5:0]  wb_adr_i,      // Bus address.
    input wire logic [3:0]  wb_sel_i,      // Byte selects.
    input wire logic [31:0] wb_dat_i,      // Write data.
    input wire logic [31:0] wb_dat_o,      // Read data.
    input wire logic        wb_ack_o,      // Acknowledge.
    input wire logic        timer_clear_o, // Timer reset pulse.
    input wire logic        pin_o,         // Pin value.
    input wire logic        pin_oe_o,      // Pin enable.
    input wire logic        compare_out_o, // Compare latch.
    input wire logic        event_flag_o,  // Event flag.
    input wire logic        wake_o         // Wake request.
);
    // ********
    // Helpers
    // ********
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req;      // A request is on the bus.
    logic wr_ack;   // A write lands at this edge.
    logic flag_clr; // Software clears the flag at this edge.
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_ack = req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign flag_clr = wr_ack && wb_adr_i == `CCU_OFS_FLAG && !wb_dat_i[0];
    // Clearing the control register, then the latch seen low.
    sequence s_ctl_zero;
        wr_ack && wb_adr_i == `CCU_OFS_CONTROL && wb_dat_i[7:0] == 8'h00;
    endsequence
    sequence s_latch_low;
        ##2 !compare_out_o;
    endsequence
    AST_ACK_RISE: assert property ($rose(req) |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    AST_DAT_TOP: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_FLAG_KEEP: assert property ($fell(event_flag_o) |-> $past(flag_clr) || $past(flag_clr, 2))
        else $error("flag cleared without software");
    AST_WAKE: assert property (wake_o |-> event_flag_o)
        else $error("wake without flag");
    AST_CLR_ONE: assert property (timer_clear_o |=> !timer_clear_o)
        else $error("timer clear longer than one cycle");
    AST_CLR_ACT: assert property (timer_clear_o |=> $changed(compare_out_o))
        else $error("no output action with timer clear");
    AST_PIN_CMP: assert property (pin_o |-> compare_out_o)
        else $error("pin high while latch low");
    AST_RST_OUT: assert property ($fell(rst_i) |-> !pin_oe_o && !compare_out_o && !event_flag_o)
        else $error("outputs not idle after reset");
    AST_ZERO_CTL: assert property (s_ctl_zero |-> s_latch_low)
        else $error("latch not low after control cleared");
endmodule

/* File: ccu_top_test.sv */
// Self-checking bench of the capture/compare unit with a timer and pin model.
// Assumes ccu_top, ccu_top_chk and ccu_timer_model compiled before it.
`timescale 1ns/1ps
`include "ccu_map.svh"
module ccu_top_test;
    logic clk_i = 1'b0, rst_i = 1'b1;           // Clock and reset.
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0;     // Bus cycle and strobe.
    logic wb_we_i = 1'b0;                       // Bus write.
    logic [5:0]  wb_adr_i = 6'h00;              // Bus address.
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;    // Bus data.
    logic wb_ack_o, timer_clear_o, pin_lvl;     // Unit answers and pin.
    logic pin_o, pin_oe_o, compare_out_o, event_flag_o, wake_o;
    logic [2:0]  alt_src_i = 3'h0;              // Other capture sources.
    logic [15:0] cnt, t_val = 16'h0;            // Timer count and load value.
    logic t_run = 1'b0, t_load = 1'b0;          // Timer controls.
    logic ext_oe = 1'b1, ext_lvl = 1'b0;        // Outside pin driver.
    int n_mismatch = 0, tests_run = 0, cyc_n = 0;
    always #5 clk_i = ~clk_i;
    ccu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_count_i(cnt),
        .timer_clear_o(timer_clear_o), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .alt_src_i(alt_src_i), .compare_out_o(compare_out_o), .event_flag_o(event_flag_o),
        .wake_o(wake_o));
    ccu_timer_model tmr (.clk_i(clk_i), .rst_i(rst_i), .run_i(t_run), .load_i(t_load),
        .load_val_i(t_val), .clear_i(timer_clear_o), .count_o(cnt), .drv_i(pin_o),
        .drv_oe_i(pin_oe_o), .ext_oe_i(ext_oe), .ext_i(ext_lvl), .pin_o(pin_lvl));
    // ********
    // Helpers
    // ********
    // Ends the run with the verdict.
    task automatic print_verdict;
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // A hung handshake is cut short here.
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle; held until ack is sampled, then released a cycle.
    task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask
    // Reads the low byte, then the high byte, with no guard against a capture between the two reads.
    task automatic rd16(output logic [15:0] v);
        rd(`CCU_OFS_VAL_LOW, v[7:0]);
        rd(`CCU_OFS_VAL_HIGH, v[15:8]);
    endtask
    // Off first, so the prescaler restarts; the flag is cleared after the change.
    task automatic setup(input logic [3:0] m, input logic [7:0] src, input logic [15:0] v);
        wr(`CCU_OFS_CONTROL, 8'h00);
        wr(`CCU_OFS_SOURCE, src);
        wr(`CCU_OFS_VAL_LOW, v[7:0]);
        wr(`CCU_OFS_VAL_HIGH, v[15:8]);
        wr(`CCU_OFS_CONTROL, {4'h8, m});
        wr(`CCU_OFS_FLAG, 8'h00);
        wr(`CCU_OFS_ENABLE, 8'h01);
    endtask
    task automatic tload(input logic [15:0] v);
        t_val <= v;
        t_load <= 1'b1;
        @(posedge clk_i);
        t_load <= 1'b0;
    endtask
    // Halted timer at t, then one level change on the pin or a side source.
    task automatic hit(input logic [15:0] t, input logic lvl, input logic alt);
        tload(t);
        if (alt)
            alt_src_i[0] <= lvl;
        else
            ext_lvl <= lvl;
        repeat (6) @(posedge clk_i);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        logic [7:0] q;
        rd(`CCU_OFS_CONTROL, q);
        chk("control", 16'h0000, 16'(q));
        rd(`CCU_OFS_SOURCE, q);
        chk("source", 16'h0080, 16'(q));
        wr(6'h3c, 8'hff);
        rd(6'h3c, q);
        chk("unmapped", 16'h0000, 16'(q));
    endtask
    // A rise, then a fall; in the any-edge mode the second capture overwrites the first.
    task automatic t_edge(input logic [3:0] m, input logic up, input logic dn);
        logic [15:0] q;
        setup(m, 8'h80, 16'h0000);
        hit(16'h1234, 1'b1, 1'b0);
        rd16(q);
        chk("value", up ? 16'h1234 : 16'h0000, q);
        chk("flag", 16'(up), 16'(event_flag_o));
        chk("wake", 16'(up), 16'(wake_o));
        wr(`CCU_OFS_FLAG, 8'h00);
        hit(16'habcd, 1'b0, 1'b0);
        rd16(q);
        chk("value", dn ? 16'habcd : (up ? 16'h1234 : 16'h0000), q);
    endtask
    // Edges counted before a restart must not count toward the next capture.
    task automatic t_pre(input logic [3:0] m, input int n, input int pre);
        logic [15:0] q;
        setup(m, 8'h80, 16'h0000);
        for (int i = 1; i <= pre; i++)
        begin
            hit(16'(i), 1'b1, 1'b0);
            hit(16'(i), 1'b0, 1'b0);
        end
        setup(m, 8'h80, 16'h0000);
        for (int i = 1; i <= n; i++)
        begin
            hit(16'(i), 1'b1, 1'b0);
            hit(16'(i), 1'b0, 1'b0);
            rd16(q);
            chk("prescaled", i == n ? 16'(n) : 16'h0000, q);
        end
    endtask
    task automatic t_alt;
        logic [15:0] q;
        setup(4'h5, 8'h81, 16'h0000);
        hit(16'h0077, 1'b1, 1'b1);
        wr(`CCU_OFS_ENABLE, 8'h00);
        rd16(q);
        chk("side source", 16'h0077, q);
        chk("wake", 16'h0000, 16'(wake_o));
        hit(16'h0099, 1'b1, 1'b0);
        rd16(q);
        chk("pin ignored", 16'h0077, q);
        wr(`CCU_OFS_SOURCE, 8'h83);
        alt_src_i[2] <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd16(q);
        chk("side source", 16'h0099, q);
    endtask
    // Timer runs through the match once; rises, clears and levels are judged.
    task automatic t_cmp(input logic [3:0] m, input logic [7:0] src, input int rises,
                         input logic fin, input int clrs);
        int nr, nc;
        logic pv;
        ext_oe <= 1'b0;
        setup(m, src, 16'h0030);
        tload(16'h0010);
        t_run <= 1'b1;
        nr = 0;
        nc = 0;
        pv = compare_out_o;
        repeat (60)
        begin
            @(posedge clk_i);
            nc += (timer_clear_o === 1'b1);
            nr += (compare_out_o === 1'b1 && pv !== 1'b1);
            pv = compare_out_o;
        end
        t_run <= 1'b0;
        chk("rises", 16'(rises), 16'(nr));
        chk("timer clears", 16'(clrs), 16'(nc));
        chk("latch", 16'(fin), 16'(compare_out_o));
        chk("pin", 16'(fin), 16'(pin_lvl));
        chk("pin enable", src[6] ? 16'(!fin) : 16'h0001, 16'(pin_oe_o));
        chk("flag", 16'h0001, 16'(event_flag_o));
        wr(`CCU_OFS_CONTROL, 8'h00);
        repeat (3) @(posedge clk_i);
        chk("latch", 16'h0000, 16'(compare_out_o));
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_edge(4'h3, 1'b1, 1'b1);
        t_edge(4'h4, 1'b0, 1'b1);
        t_edge(4'h5, 1'b1, 1'b0);
        t_pre(4'h6, 4, 2);
        t_pre(4'h7, 16, 0);
        t_alt;
        t_cmp(4'h1, 8'h00, 1, 1'b1, 1);
        t_cmp(4'h2, 8'h00, 1, 1'b1, 0);
        t_cmp(4'h8, 8'h00, 1, 1'b1, 0);
        t_cmp(4'h9, 8'h00, 0, 1'b0, 0);
        t_cmp(4'ha, 8'h00, 1, 1'b0, 0);
        t_cmp(4'hb, 8'h00, 1, 1'b0, 1);
        t_cmp(4'h8, 8'h40, 1, 1'b1, 0);
        print_verdict;
    end
endmodule
bind ccu_top ccu_top_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_clear_o, .pin_o, .pin_oe_o,
    .compare_out_o, .event_flag_o, .wake_o);
